/* src/sco_pkg.sv */
/*
  Constants, types and a range-check helper function for the start-command decoder and
  output-terminal selector. Assumes one 100 MHz clock and parameter values
  that are written through the block's own parameter write port.
*/
package sco_pkg;

  localparam int PW = 14;
  localparam int FW = 16;
  localparam int NTERM = 5;

  // Parameter numbers used as write addresses.
  localparam logic [7:0] ADDR_IN_SEL_BASE = 8'hb2;
  localparam logic [7:0] ADDR_IN_SEL_A = 8'hb2;
  localparam logic [7:0] ADDR_IN_SEL_B = 8'hb3;
  localparam logic [7:0] ADDR_IN_SEL_LAST = 8'hb6;
  localparam logic [7:0] ADDR_OC_SEL = 8'hbe;
  localparam logic [7:0] ADDR_RELAY_SEL = 8'hc0;
  localparam logic [7:0] ADDR_SECOND_OC_SEL = 8'hc5;
  localparam logic [7:0] ADDR_STOP_MODE = 8'hfa;

  // Stop-mode values.
  localparam logic [PW-1:0] STOP_SEP_LO = 14'h0000;
  localparam logic [PW-1:0] STOP_SEP_HI = 14'h0064;
  localparam logic [PW-1:0] STOP_COMB_LO = 14'h03e8;
  localparam logic [PW-1:0] STOP_COMB_HI = 14'h044c;
  localparam logic [PW-1:0] STOP_SEP_DECEL = 14'h270f;
  localparam logic [PW-1:0] STOP_COMB_DECEL = 14'h22b8;

  // Input function codes and reset values of the input selectors.
  localparam logic [PW-1:0] IN_FN_FWD = 14'h003c;
  localparam logic [PW-1:0] IN_FN_REV = 14'h003d;
  localparam logic [PW-1:0] IN_FN_JOG = 14'h0005;
  localparam logic [PW-1:0] IN_FN_CUT = 14'h0018;
  localparam logic [PW-1:0] IN_FN_HOLD = 14'h0019;
  localparam logic [PW-1:0] IN_FN_NONE = 14'h270f;
  localparam logic [PW-1:0] IN_SEL_RST [NTERM] = '{14'h003c, 14'h003d, 14'h0005, 14'h0018, 14'h270f};

  // Output function codes.
  localparam logic [PW-1:0] OUT_FN_RUN = 14'h0000;
  localparam logic [PW-1:0] OUT_FN_AT_SPEED = 14'h0001;
  localparam logic [PW-1:0] OUT_FN_OVERLOAD = 14'h0003;
  localparam logic [PW-1:0] OUT_FN_FREQ_DET = 14'h0004;
  localparam logic [PW-1:0] OUT_FN_BRAKE_PRE = 14'h0007;
  localparam logic [PW-1:0] OUT_FN_SAFE = 14'h0050;
  localparam logic [PW-1:0] OUT_FN_SAFE2 = 14'h0051;
  localparam logic [PW-1:0] OUT_FN_ALARM = 14'h0063;
  localparam logic [PW-1:0] OUT_SINK_OFS = 14'h0064;
  localparam logic [PW-1:0] OUT_SINK_END = 14'h00c8;
  localparam logic [PW-1:0] OC_SEL_RST = 14'h0000;
  localparam logic [PW-1:0] RELAY_SEL_RST = 14'h0063;
  localparam logic [PW-1:0] SECOND_OC_SEL_RST = 14'h0050;
  localparam logic [7:0] BRAKE_PRE_PCT = 8'h55;
  localparam logic [7:0] FULL_PCT = 8'h64;

  typedef struct packed {
    logic running;
    logic at_speed;
    logic overload;
    logic freq_detect;
    logic brake_prealarm;
    logic alarm;
    logic safe;
    logic safe_fault_free;
  } sco_status_t;

  typedef struct packed {
    logic run;
    logic rev;
    logic coast;
  } sco_cmd_t;

  function automatic logic sco_in_range(input logic [PW-1:0] v, input logic [PW-1:0] lo, input logic [PW-1:0] hi);
    sco_in_range = (v >= lo) && (v <= hi);
  endfunction : sco_in_range

endpackage : sco_pkg

/* src/sco_start_latch.sv */
/*
  Start-command decoder with the three-wire self-holding latch.
  Assumes the start and stop-hold levels are already decoded from
  the terminals and synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sco_start_latch
  import sco_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Decoded inputs.
  input wire logic fwd_start_in,
  input wire logic rev_start_in,
  input wire logic hold_active,
  input wire logic combined_mode,
  // Command.
  output logic run,
  output logic rev,
  output logic hold_stop
);
  logic fwd_q;
  logic rev_q;
  logic held_run;
  logic held_rev;
  logic fwd_fall;
  logic rev_fall;

  assign fwd_fall = fwd_q && !fwd_start_in;
  assign rev_fall = rev_q && !rev_start_in;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
    end
    else
    begin
      fwd_q <= fwd_start_in;
      rev_q <= rev_start_in;
    end
  end

  // The latch is only ever cleared by a stop-hold release or reset, so an output cut leaves it alone.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      held_run <= 1'b0;
      held_rev <= 1'b0;
    end
    else if (!hold_active)
    begin
      held_run <= 1'b0;
      held_rev <= 1'b0;
    end
    else if (combined_mode)
    begin
      if (fwd_fall)
      begin
        held_run <= 1'b1;
        held_rev <= rev_start_in;
      end
    end
    else if (fwd_fall)
    begin
      held_run <= 1'b1;
      held_rev <= 1'b0;
    end
    else if (rev_fall)
    begin
      held_run <= 1'b1;
      held_rev <= 1'b1;
    end
  end

  // A release of the hold while latched stops with deceleration, not coasting.
  // It is combinational so that it stands at the very edge where the run command drops.
  assign hold_stop = held_run && !hold_active;

  // Two-wire decode, or the latched command while the hold is on.
  always_comb
  begin
    if (hold_active)
    begin
      run = held_run;
      rev = held_rev;
    end
    else if (combined_mode)
    begin
      run = fwd_start_in;
      rev = rev_start_in;
    end
    else
    begin
      run = fwd_start_in ^ rev_start_in;
      rev = rev_start_in && !fwd_start_in;
    end
  end
endmodule : sco_start_latch
`default_nettype wire

/* src/sco_out_mux.sv */
/*
  One output terminal: picks an internal status by function code and
  applies source or sink polarity. Assumes a registered status word.
*/
`timescale 1ns/1ps
`default_nettype none
module sco_out_mux
  import sco_pkg::*;
(
  input wire logic [PW-1:0] code,
  input wire sco_status_t status,
  output logic term
);
  logic sink;
  logic [PW-1:0] base;
  logic level;

  always_comb
  begin
    sink = sco_in_range(code, OUT_SINK_OFS, OUT_SINK_END - 14'h0001);
    base = sink ? code - OUT_SINK_OFS : code;
    case (base)
      OUT_FN_RUN: level = status.running;
      OUT_FN_AT_SPEED: level = status.at_speed;
      OUT_FN_OVERLOAD: level = status.overload;
      OUT_FN_FREQ_DET: level = status.freq_detect;
      OUT_FN_BRAKE_PRE: level = status.brake_prealarm;
      OUT_FN_SAFE: level = status.safe;
      OUT_FN_SAFE2: level = status.safe_fault_free;
      OUT_FN_ALARM: level = status.alarm;
      default: level = 1'b0;
    endcase
    // Codes of 200 and up hold the terminal inactive in either polarity; unsupported sink codes below 200 drive it high.
    term = sink ? !level : level;
    if (!sco_in_range(code, OUT_FN_RUN, OUT_SINK_END - 14'h0001))
      term = 1'b0;
  end
endmodule : sco_out_mux
`default_nettype wire

/* src/sco_top.sv */
/*
  Start-command decoder and output-terminal selector of a motor drive.
  Assumes all inputs are synchronous to SYS_CLK and that parameters are
  written one at a time through the parameter write port.
*/
`timescale 1ns/1ps
`default_nettype none
module sco_top
  import sco_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Input terminals, active high contacts.
  input wire logic [sco_pkg::NTERM-1:0] TERM_IN,
  input wire logic JOG_ENABLE,
  // Parameter write port.
  input wire logic PARAM_WR,
  input wire logic [7:0] PARAM_ADDR,
  input wire logic [sco_pkg::PW-1:0] PARAM_WDATA,
  input wire logic [15:0] EXT_PARAM_ACCESS,
  output logic PARAM_WR_ERR,
  // Drive status sources.
  input wire logic [sco_pkg::FW-1:0] OUT_FREQ,
  input wire logic [sco_pkg::FW-1:0] SET_FREQ,
  input wire logic [sco_pkg::FW-1:0] START_FREQ_PARAM,
  input wire logic [sco_pkg::FW-1:0] FWD_DETECT_THRESHOLD,
  input wire logic [sco_pkg::FW-1:0] REV_DETECT_THRESHOLD,
  input wire logic [7:0] BRAKE_DUTY_PARAM,
  input wire logic [7:0] BRAKE_DUTY_USED,
  input wire logic STALL_ACTIVE,
  input wire logic ALARM_ACTIVE,
  input wire logic SAFETY_STOP_ACTIVE,
  input wire logic SAFETY_FAULT,
  // Drive command.
  output logic RUN_CMD,
  output logic REV_CMD,
  output logic OUTPUT_ENABLE,
  output logic COAST_STOP,
  // Output terminals.
  output logic OC_RUN_TERM,
  output logic RELAY_TERM,
  output logic SECOND_OC_TERM,
  // Parameter readback.
  output logic [sco_pkg::PW-1:0] STOP_MODE_VALUE,
  output logic HOLD_AVAILABLE
);
  logic [PW-1:0] in_sel [NTERM];
  logic [PW-1:0] oc_out_sel_param;
  logic [PW-1:0] relay_out_sel_param;
  logic [PW-1:0] second_oc_sel_param;
  logic [PW-1:0] stop_mode_param;
  logic fwd_start_in;
  logic rev_start_in;
  logic stop_hold_in;
  logic jog_in;
  logic output_cut_in;
  logic hold_active;
  logic hold_q;
  logic combined_mode;
  logic coast_mode;
  logic latch_run;
  logic latch_rev;
  logic hold_stop;
  logic sel_write;
  logic in_write;
  logic wr_ok;
  logic [2:0] in_idx;
  sco_status_t status;
  logic at_speed_out;
  logic freq_detect_out;
  logic brake_prealarm_out;
  logic next_oc;
  logic next_relay;
  logic next_second;

  // Parameter writes.

  always_comb
  begin
    in_idx = 3'(PARAM_ADDR - ADDR_IN_SEL_BASE);
    in_write = (PARAM_ADDR >= ADDR_IN_SEL_A) && (PARAM_ADDR <= ADDR_IN_SEL_LAST);
    sel_write = (PARAM_ADDR == ADDR_OC_SEL) || (PARAM_ADDR == ADDR_RELAY_SEL) ||
                (PARAM_ADDR == ADDR_SECOND_OC_SEL);
    wr_ok = 1'b1;
    if (EXT_PARAM_ACCESS != 16'h0000)
      wr_ok = 1'b0;
    else if (in_write && (PARAM_WDATA == IN_FN_FWD) && (PARAM_ADDR != ADDR_IN_SEL_A))
      wr_ok = 1'b0;
    else if (in_write && (PARAM_WDATA == IN_FN_REV) && (PARAM_ADDR != ADDR_IN_SEL_B))
      wr_ok = 1'b0;
    else if (!in_write && !sel_write && (PARAM_ADDR != ADDR_STOP_MODE))
      wr_ok = 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      PARAM_WR_ERR <= 1'b0;
    else
      PARAM_WR_ERR <= PARAM_WR && !wr_ok;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < NTERM; i++)
        in_sel[i] <= IN_SEL_RST[i];
    end
    else if (PARAM_WR && wr_ok && in_write)
      in_sel[in_idx] <= PARAM_WDATA;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      oc_out_sel_param <= OC_SEL_RST;
    else if (PARAM_WR && wr_ok && (PARAM_ADDR == ADDR_OC_SEL))
      oc_out_sel_param <= PARAM_WDATA;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      relay_out_sel_param <= RELAY_SEL_RST;
    else if (PARAM_WR && wr_ok && (PARAM_ADDR == ADDR_RELAY_SEL))
      relay_out_sel_param <= PARAM_WDATA;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      second_oc_sel_param <= SECOND_OC_SEL_RST;
    else if (PARAM_WR && wr_ok && (PARAM_ADDR == ADDR_SECOND_OC_SEL))
      second_oc_sel_param <= PARAM_WDATA;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      stop_mode_param <= STOP_SEP_DECEL;
    else if (PARAM_WR && wr_ok && (PARAM_ADDR == ADDR_STOP_MODE))
      stop_mode_param <= PARAM_WDATA;
  end

  assign STOP_MODE_VALUE = stop_mode_param;

  // Terminal decode.

  always_comb
  begin
    fwd_start_in = TERM_IN[0] && (in_sel[0] == IN_FN_FWD);
    rev_start_in = TERM_IN[1] && (in_sel[1] == IN_FN_REV);
    stop_hold_in = 1'b0;
    jog_in = 1'b0;
    output_cut_in = 1'b0;
    HOLD_AVAILABLE = 1'b0;
    for (int i = 0; i < NTERM; i++)
    begin
      if (in_sel[i] == IN_FN_HOLD)
      begin
        HOLD_AVAILABLE = 1'b1;
        stop_hold_in = stop_hold_in | TERM_IN[i];
      end
      if (in_sel[i] == IN_FN_JOG)
        jog_in = jog_in | TERM_IN[i];
      if (in_sel[i] == IN_FN_CUT)
        output_cut_in = output_cut_in | TERM_IN[i];
    end
    hold_active = (jog_in && JOG_ENABLE) ? hold_q : stop_hold_in;
    combined_mode = sco_in_range(stop_mode_param, STOP_COMB_LO, STOP_COMB_HI) ||
                    (stop_mode_param == STOP_COMB_DECEL);
    coast_mode = sco_in_range(stop_mode_param, STOP_SEP_LO, STOP_SEP_HI) ||
                 sco_in_range(stop_mode_param, STOP_COMB_LO, STOP_COMB_HI);
  end

  // While jogging the hold keeps its last state, so jogging neither arms nor drops self-holding.
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      hold_q <= 1'b0;
    else
      hold_q <= hold_active;
  end

  sco_start_latch u_latch (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .fwd_start_in(fwd_start_in),
    .rev_start_in(rev_start_in),
    .hold_active(hold_active),
    .combined_mode(combined_mode),
    .run(latch_run),
    .rev(latch_rev),
    .hold_stop(hold_stop)
  );

  // Drive command. The cut gates the output but leaves the decoded command intact.
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      RUN_CMD <= 1'b0;
      REV_CMD <= 1'b0;
      OUTPUT_ENABLE <= 1'b0;
    end
    else
    begin
      RUN_CMD <= latch_run;
      if (latch_run)
        REV_CMD <= latch_rev;
      OUTPUT_ENABLE <= latch_run && !output_cut_in;
    end
  end

  // Coasting follows a start removal in coast modes, or any output cut; a hold release decelerates.
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      COAST_STOP <= 1'b0;
    else if (output_cut_in)
      COAST_STOP <= 1'b1;
    else if (latch_run)
      COAST_STOP <= 1'b0;
    else if (RUN_CMD)
      COAST_STOP <= coast_mode && !hold_stop;
  end

  // Status conditions, registered so each terminal sees a stable word.

  always_comb
  begin
    at_speed_out = OUTPUT_ENABLE && (OUT_FREQ >= SET_FREQ);
    if (REV_CMD)
      freq_detect_out = OUT_FREQ >= REV_DETECT_THRESHOLD;
    else
      freq_detect_out = OUT_FREQ >= FWD_DETECT_THRESHOLD;
    // Both sides scaled to percent of a percent so no division is needed.
    brake_prealarm_out = (16'(BRAKE_DUTY_USED) * 16'(FULL_PCT)) >=
                         (16'(BRAKE_DUTY_PARAM) * 16'(BRAKE_PRE_PCT));
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      status <= '0;
    else
    begin
      status.running <= OUTPUT_ENABLE && (OUT_FREQ >= START_FREQ_PARAM);
      status.at_speed <= at_speed_out;
      status.overload <= STALL_ACTIVE;
      status.freq_detect <= freq_detect_out;
      status.brake_prealarm <= brake_prealarm_out && (BRAKE_DUTY_PARAM != 8'h00);
      status.alarm <= ALARM_ACTIVE;
      status.safe <= SAFETY_STOP_ACTIVE;
      status.safe_fault_free <= !SAFETY_FAULT;
    end
  end

  // Output terminals.

  sco_out_mux u_oc (
    .code(oc_out_sel_param),
    .status(status),
    .term(next_oc)
  );

  sco_out_mux u_relay (
    .code(relay_out_sel_param),
    .status(status),
    .term(next_relay)
  );

  sco_out_mux u_second (
    .code(second_oc_sel_param),
    .status(status),
    .term(next_second)
  );

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      OC_RUN_TERM <= 1'b0;
    else
      OC_RUN_TERM <= next_oc;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      RELAY_TERM <= 1'b0;
    else
      RELAY_TERM <= next_relay;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      SECOND_OC_TERM <= 1'b0;
    else
      SECOND_OC_TERM <= next_second;
  end

endmodule : sco_top
`default_nettype wire

/* sim/sco_contacts.sv */
/*
  Contact model for the input terminals: switches and relay wiring.
  Assumes the bench sets the wanted contact levels on press.
*/
`timescale 1ns/1ps
`default_nettype none
module sco_contacts
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Contact levels wanted and terminal levels seen by the drive.
  input wire logic [4:0] press,
  output logic [4:0] term
);
  // Contacts settle one clock after they are thrown, so no level reaches the drive mid-cycle.
  // A direction change in self-holding separate mode is one press and release of the other start contact; combined mode taps forward with reverse held.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      term <= 5'h00;
    else
      term <= press;
  end
endmodule : sco_contacts
`default_nettype wire

/* sim/sco_checker.sv */
/*
  Port assertions for the start decoder and terminal selector.
  Assumes input selectors 178..181 keep their reset functions.
*/
`timescale 1ns/1ps
`default_nettype none
module sco_checker
  import sco_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Watched ports.
  input wire logic [sco_pkg::NTERM-1:0] TERM_IN,
  input wire logic JOG_ENABLE,
  input wire logic PARAM_WR,
  input wire logic [7:0] PARAM_ADDR,
  input wire logic [sco_pkg::PW-1:0] PARAM_WDATA,
  input wire logic [15:0] EXT_PARAM_ACCESS,
  input wire logic PARAM_WR_ERR,
  input wire logic RUN_CMD,
  input wire logic REV_CMD,
  input wire logic OUTPUT_ENABLE,
  input wire logic COAST_STOP,
  input wire logic [sco_pkg::PW-1:0] STOP_MODE_VALUE,
  input wire logic HOLD_AVAILABLE
);
  logic sep;
  logic comb;
  logic w2;
  assign sep = (STOP_MODE_VALUE <= STOP_SEP_HI) || (STOP_MODE_VALUE == STOP_SEP_DECEL);
  assign comb = sco_in_range(STOP_MODE_VALUE, STOP_COMB_LO, STOP_COMB_HI) || (STOP_MODE_VALUE == STOP_COMB_DECEL);
  assign w2 = !HOLD_AVAILABLE;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  sequence s_fwd_tap;
    HOLD_AVAILABLE && sep && TERM_IN == 5'h11 ##1 TERM_IN == 5'h10;
  endsequence
  sequence s_hold_drop;
    HOLD_AVAILABLE && $fell(TERM_IN[4]) && !$past(TERM_IN[2]) && TERM_IN == 5'h00 ##1 TERM_IN == 5'h00;
  endsequence
  a_sep_run: assert property (w2 && sep |=> RUN_CMD == ($past(TERM_IN[0]) ^ $past(TERM_IN[1])))
    else $error("separate mode run decode wrong");
  a_sep_dir: assert property (w2 && sep && (TERM_IN[0] ^ TERM_IN[1]) |=> REV_CMD == $past(TERM_IN[1]))
    else $error("separate mode direction wrong");
  a_comb_decode: assert property (w2 && comb |=> RUN_CMD == $past(TERM_IN[0]) && (!RUN_CMD || REV_CMD == $past(TERM_IN[1])))
    else $error("combined mode decode wrong");
  a_coast_select: assert property (w2 && $fell(RUN_CMD) && (STOP_MODE_VALUE <= STOP_SEP_HI ||
    sco_in_range(STOP_MODE_VALUE, STOP_COMB_LO, STOP_COMB_HI)) |-> ##[0:1] COAST_STOP)
    else $error("coast stop missing");
  a_decel_select: assert property (w2 && STOP_MODE_VALUE == STOP_SEP_DECEL && !TERM_IN[3] && !COAST_STOP |=> !COAST_STOP)
    else $error("coast in decelerate mode");
  a_cut_output: assert property (TERM_IN[3] |=> !OUTPUT_ENABLE)
    else $error("output not cut");
  a_cut_keeps: assert property (HOLD_AVAILABLE && RUN_CMD && TERM_IN == 5'h18 |=> RUN_CMD)
    else $error("cut cleared held start");
  a_latch_start: assert property (s_fwd_tap ##1 TERM_IN == 5'h10 [*2] |-> RUN_CMD && !REV_CMD)
    else $error("three-wire start not held");
  a_hold_release: assert property (s_hold_drop |=> !RUN_CMD)
    else $error("hold release did not stop");
  a_hold_decel: assert property (HOLD_AVAILABLE && $fell(TERM_IN[4]) && !$past(TERM_IN[2]) && RUN_CMD
    && !TERM_IN[3] |=> !COAST_STOP)
    else $error("hold release coasted");
  a_jog_ignores: assert property (HOLD_AVAILABLE && JOG_ENABLE && TERM_IN == 5'h04 && $past(TERM_IN[2]) && RUN_CMD |=> RUN_CMD)
    else $error("hold not ignored under jog");
  a_access_lock: assert property (PARAM_WR && EXT_PARAM_ACCESS != 16'h0000 |=> PARAM_WR_ERR && $stable(STOP_MODE_VALUE))
    else $error("write accepted while locked");
  a_fwd_only_a: assert property (PARAM_WR && PARAM_ADDR inside {[ADDR_IN_SEL_B:ADDR_IN_SEL_LAST]}
    && PARAM_WDATA == IN_FN_FWD |=> PARAM_WR_ERR)
    else $error("forward start taken elsewhere");
endmodule : sco_checker
bind sco_top sco_checker i_chk (.SYS_CLK, .RSTN, .TERM_IN, .JOG_ENABLE, .PARAM_WR, .PARAM_ADDR, .PARAM_WDATA,
  .EXT_PARAM_ACCESS, .PARAM_WR_ERR, .RUN_CMD, .REV_CMD, .OUTPUT_ENABLE, .COAST_STOP, .STOP_MODE_VALUE, .HOLD_AVAILABLE);
`default_nettype wire

/* sim/sco_top_tb_top.sv */
/*
  Self-checking bench for the start decoder and terminal selector.
  Assumes input selectors 178..181 keep their reset functions.
*/
`timescale 1ns/1ps
`default_nettype none
module sco_top_tb_top;
  import sco_pkg::*;
  localparam logic [PW-1:0] TCODE [9] = '{14'h0003, 14'h0067, 14'h0004, 14'h0068, 14'h0007, 14'h006b, 14'h0001,
    14'h0065, 14'h0063};
  localparam logic [8:0] TEXP = 9'h195;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] press = 5'h00;
  logic [NTERM-1:0] term;
  logic jog_en = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [PW-1:0] wdata = 14'h0000;
  logic [15:0] ext = 16'h0000;
  logic [FW-1:0] ofreq = 16'h0032;
  logic [FW-1:0] rthr = 16'h00c8;
  logic [7:0] bused = 8'h55;
  logic stall = 1'b1;
  logic safe_stop = 1'b1;
  logic alarm = 1'b1;
  logic wr_err, run, rev, oen, coast, oc_t, rel_t, so_t, hold_av;
  logic [PW-1:0] mode;
  int n_fail = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  sco_contacts i_contacts (.clk(clk), .rst_n(rst_n), .press(press), .term(term));
  sco_top i_dut (.SYS_CLK(clk), .RSTN(rst_n), .TERM_IN(term), .JOG_ENABLE(jog_en), .PARAM_WR(wr), .PARAM_ADDR(addr),
    .PARAM_WDATA(wdata), .EXT_PARAM_ACCESS(ext), .PARAM_WR_ERR(wr_err), .OUT_FREQ(ofreq), .SET_FREQ(16'h003c),
    .START_FREQ_PARAM(16'h0005), .FWD_DETECT_THRESHOLD(16'h0028), .REV_DETECT_THRESHOLD(rthr),
    .BRAKE_DUTY_PARAM(8'h64), .BRAKE_DUTY_USED(bused), .STALL_ACTIVE(stall), .ALARM_ACTIVE(alarm),
    .SAFETY_STOP_ACTIVE(safe_stop), .SAFETY_FAULT(1'b0), .RUN_CMD(run), .REV_CMD(rev), .OUTPUT_ENABLE(oen),
    .COAST_STOP(coast), .OC_RUN_TERM(oc_t), .RELAY_TERM(rel_t), .SECOND_OC_TERM(so_t), .STOP_MODE_VALUE(mode),
    .HOLD_AVAILABLE(hold_av));
  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [PW-1:0] got, input logic [PW-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic set_in(input logic [4:0] v);
    @(posedge clk);
    press <= v;
    wait_cyc(6);
  endtask : set_in
  // Drives one write and checks the refusal pulse that follows it.
  task automatic wr_par(input logic [7:0] a, input logic [PW-1:0] d, input logic err);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    chk_bit(wr_err, err);
    wait_cyc(3);
  endtask : wr_par
  task automatic t_reset();
    chk_word(mode, STOP_SEP_DECEL);
    chk_bit(hold_av, 1'b0);
    chk_bit(run, 1'b0);
    chk_bit(oc_t, 1'b0);
    chk_bit(rel_t, 1'b1);
    chk_bit(so_t, 1'b1);
  endtask : t_reset
  task automatic t_two_wire();
    for (int i = 0; i < 4; i++)
    begin
      set_in(5'(i));
      chk_bit(run, i[0] ^ i[1]);
      chk_bit(oen, i[0] ^ i[1]);
      if (i == 2)
        chk_bit(rev, 1'b1);
    end
    wr_par(ADDR_STOP_MODE, STOP_COMB_DECEL, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      set_in(5'(i));
      chk_bit(run, i[0]);
      if (i[0])
        chk_bit(rev, i[1]);
    end
    set_in(5'h00);
  endtask : t_two_wire
  task automatic t_coast();
    wr_par(ADDR_STOP_MODE, STOP_SEP_HI, 1'b0);
    set_in(5'h01);
    set_in(5'h00);
    chk_bit(coast, 1'b1);
    wr_par(ADDR_STOP_MODE, STOP_COMB_LO, 1'b0);
    set_in(5'h01);
    set_in(5'h00);
    chk_bit(coast, 1'b1);
    wr_par(ADDR_STOP_MODE, STOP_SEP_DECEL, 1'b0);
    set_in(5'h01);
    set_in(5'h00);
    chk_bit(coast, 1'b0);
  endtask : t_coast
  task automatic t_params();
    @(posedge clk);
    ext <= 16'h0001;
    wr_par(ADDR_RELAY_SEL, OUT_FN_OVERLOAD, 1'b1);
    chk_bit(rel_t, 1'b1);
    @(posedge clk);
    ext <= 16'h0000;
    wr_par(ADDR_IN_SEL_LAST, IN_FN_FWD, 1'b1);
    wr_par(ADDR_IN_SEL_A, IN_FN_REV, 1'b1);
    wr_par(8'h01, 14'h0000, 1'b1);
  endtask : t_params
  task automatic t_terms();
    for (int i = 0; i < 9; i++)
    begin
      wr_par(ADDR_RELAY_SEL, TCODE[i], 1'b0);
      chk_bit(rel_t, TEXP[i]);
    end
    wr_par(ADDR_RELAY_SEL, OUT_FN_BRAKE_PRE, 1'b0);
    @(posedge clk);
    bused <= 8'h54;
    wait_cyc(3);
    chk_bit(rel_t, 1'b0);
    @(posedge clk);
    bused <= 8'h55;
    wr_par(ADDR_RELAY_SEL, OUT_FN_ALARM, 1'b0);
    @(posedge clk);
    alarm <= 1'b0;
    wait_cyc(3);
    chk_bit(rel_t, 1'b0);
    @(posedge clk);
    alarm <= 1'b1;
  endtask : t_terms
  task automatic t_three_wire();
    wr_par(ADDR_IN_SEL_LAST, IN_FN_HOLD, 1'b0);
    chk_bit(hold_av, 1'b1);
    set_in(5'h10);
    set_in(5'h11);
    chk_bit(run, 1'b0);
    set_in(5'h10);
    chk_bit(run, 1'b1);
    chk_bit(oc_t, 1'b1);
    set_in(5'h12);
    set_in(5'h10);
    chk_bit(rev, 1'b1);
    wr_par(ADDR_SECOND_OC_SEL, OUT_FN_FREQ_DET, 1'b0);
    chk_bit(so_t, 1'b0);
    set_in(5'h18);
    chk_bit(oen, 1'b0);
    chk_bit(run, 1'b1);
    set_in(5'h19);
    set_in(5'h18);
    chk_bit(oen, 1'b0);
    set_in(5'h10);
    chk_bit(oen, 1'b1);
    @(posedge clk);
    jog_en <= 1'b1;
    set_in(5'h14);
    set_in(5'h04);
    chk_bit(run, 1'b1);
    set_in(5'h14);
    set_in(5'h10);
    @(posedge clk);
    jog_en <= 1'b0;
    set_in(5'h00);
    chk_bit(run, 1'b0);
    chk_bit(coast, 1'b0);
    wr_par(ADDR_STOP_MODE, STOP_COMB_LO, 1'b0);
    set_in(5'h10);
    set_in(5'h13);
    set_in(5'h12);
    chk_bit(run, 1'b1);
    chk_bit(rev, 1'b1);
    set_in(5'h00);
    chk_bit(run, 1'b0);
    chk_bit(coast, 1'b0);
  endtask : t_three_wire
  initial
  begin
    #400000;
    n_fail++;
    complete_run();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_cyc(4);
    t_reset();
    t_two_wire();
    t_coast();
    t_params();
    t_terms();
    t_three_wire();
    complete_run();
  end
endmodule : sco_top_tb_top
`default_nettype wire
